// File: hw/pcg_map.svh
// Address map, field positions, reset values and masks of the peripheral clock gate bank
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses on the register port)
// ****************************************************************
`define PCG_ADDR_W          16
`define PCG_GATE_FOUR_OFS   16'h1034
`define PCG_GATE_STAT_OFS   16'h1134

// ****************************************************************
// Gate bit positions in the gate register
// ****************************************************************
`define PCG_POS_TWO_WIRE_A  6
`define PCG_POS_TWO_WIRE_B  7
`define PCG_POS_ASYNC_A     10
`define PCG_POS_ASYNC_B     11
`define PCG_POS_ASYNC_C     12
`define PCG_POS_USB         18
`define PCG_POS_COMPARATOR  19
`define PCG_POS_SERIAL_A    22
`define PCG_POS_SERIAL_B    23

// ****************************************************************
// Masks and reset values
// ****************************************************************
`define PCG_RSV_ONES        32'hF000_0030
`define PCG_WR_MASK         32'h00CC_1CC0
`define PCG_GATE_RST        32'h0000_0000
`define PCG_NUM_GATES       9

`endif

// File: hw/pcg_pkg.sv
// Types shared by the peripheral clock gate bank
package pcg_pkg;

  // ****************************************************************
  // Per-gate sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    pcg_st_off     = 4'b0001,  // Clock withheld, steady
    pcg_st_rise    = 4'b0010,  // Clock just enabled, dwell cycle
    pcg_st_on      = 4'b0100,  // Clock delivered, steady
    pcg_st_fall    = 4'b1000   // Clock just stopped, dwell cycle
  } pcg_gate_e;

  // One enable per gated peripheral, index order low bit first
  typedef logic [8:0]  pcg_gate_vec_t;
  typedef logic [31:0] pcg_word_t;

endpackage

// File: hw/pcg_gate_cell.sv
// One glitch-free clock enable sequencer for a single peripheral
module pcg_gate_cell (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Requested state from the gate register
  input  wire logic req,
  // Registered enable towards the peripheral clock gate
  output logic      en_ff
);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  pcg_pkg::pcg_gate_e state_ff;  // Current state
  pcg_pkg::pcg_gate_e nxt_state; // Next state

  // Each change of the enable is held for two cycles, so rapid software
  // toggling can never produce a runt enable pulse at the gate
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pcg_pkg::pcg_st_off:  if (req) nxt_state = pcg_pkg::pcg_st_rise;
      pcg_pkg::pcg_st_rise: nxt_state = pcg_pkg::pcg_st_on;
      pcg_pkg::pcg_st_on:   if (!req) nxt_state = pcg_pkg::pcg_st_fall;
      pcg_pkg::pcg_st_fall: nxt_state = pcg_pkg::pcg_st_off;
      default:              nxt_state = pcg_pkg::pcg_st_off;
    endcase
  end

  // State register, every gate starts off
  always_ff @(posedge clk) begin
    if (!rstn) state_ff <= pcg_pkg::pcg_st_off;
    else       state_ff <= nxt_state;
  end

  // Enable comes straight from a flop, so it moves only after a rising edge
  always_ff @(posedge clk) begin
    if (!rstn) en_ff <= 1'b0;
    else       en_ff <= (nxt_state == pcg_pkg::pcg_st_rise) || (nxt_state == pcg_pkg::pcg_st_on);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_cell_min_dwell: assert property (
    @(posedge clk) disable iff (!rstn) $changed(en_ff) |=> $stable(en_ff))
    else $error("gate enable changed twice in two cycles");

  a_cell_follows: assert property (
    @(posedge clk) disable iff (!rstn) $rose(en_ff) |-> $past(req))
    else $error("gate enable rose without a request");

endmodule

// File: hw/pcg_rd_port.sv
// Read data register of the gate bank register port
module pcg_rd_port (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Read strobe and selected word
  input  wire logic               rd,
  input  wire pcg_pkg::pcg_word_t rd_word,
  // Registered read data
  output pcg_pkg::pcg_word_t      rdata_ff
);

  // ****************************************************************
  // Read data register
  // ****************************************************************
  // Data stand only in the cycle after the strobe, zero otherwise,
  // which keeps stale register contents off the shared read bus
  always_ff @(posedge clk) begin
    if (!rstn)   rdata_ff <= 32'h0000_0000;
    else if (rd) rdata_ff <= rd_word;
    else         rdata_ff <= 32'h0000_0000;
  end

endmodule

// File: hw/pcg_gate_bank.sv
// Peripheral clock gate bank: gate register, readback and per-peripheral enables
//
// Operation
// - Reserved bits 31-28, 5-4 read one
// - Other reserved bits read zero, writes ignored
// - Bit 23 gates second serial peripheral
// - Bit 22 gates first serial peripheral
// - Bit 19 gates comparator clock
// - Bit 18 gates USB unit clock
// - Bit 12 gates third async serial
// - Bit 11 gates second async serial
// - Bit 10 gates first async serial
// - Bit 7 gates second two-wire unit
// - Bit 6 gates first two-wire unit
`include "pcg_map.svh"

module pcg_gate_bank #(
  parameter int ADDR_W = `PCG_ADDR_W  // Register port address width
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Peripheral clock enables
  output logic                   two_wire_a_gate,
  output logic                   two_wire_b_gate,
  output logic                   async_serial_a_gate,
  output logic                   async_serial_b_gate,
  output logic                   async_serial_c_gate,
  output logic                   usb_unit_gate,
  output logic                   comparator_gate,
  output logic                   serial_periph_a_gate,
  output logic                   serial_periph_b_gate
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Gather the gate bits of a register word into the enable vector
  function automatic pcg_pkg::pcg_gate_vec_t word_to_vec(input pcg_pkg::pcg_word_t w);
    word_to_vec = {w[`PCG_POS_SERIAL_B], w[`PCG_POS_SERIAL_A],
                   w[`PCG_POS_COMPARATOR], w[`PCG_POS_USB],
                   w[`PCG_POS_ASYNC_C], w[`PCG_POS_ASYNC_B], w[`PCG_POS_ASYNC_A],
                   w[`PCG_POS_TWO_WIRE_B], w[`PCG_POS_TWO_WIRE_A]};
  endfunction

  // Scatter an enable vector back to its register positions,
  // reserved ones forced, all other reserved bits zero
  function automatic pcg_pkg::pcg_word_t vec_to_word(input pcg_pkg::pcg_gate_vec_t v);
    pcg_pkg::pcg_word_t w;
    w = `PCG_RSV_ONES;
    w[`PCG_POS_TWO_WIRE_A] = v[0];
    w[`PCG_POS_TWO_WIRE_B] = v[1];
    w[`PCG_POS_ASYNC_A]    = v[2];
    w[`PCG_POS_ASYNC_B]    = v[3];
    w[`PCG_POS_ASYNC_C]    = v[4];
    w[`PCG_POS_USB]        = v[5];
    w[`PCG_POS_COMPARATOR] = v[6];
    w[`PCG_POS_SERIAL_A]   = v[7];
    w[`PCG_POS_SERIAL_B]   = v[8];
    vec_to_word = w;
  endfunction

  // Address compare used for both strobes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic gate_sel;  // Gate register addressed
  logic stat_sel;  // Live enable status addressed

  assign gate_sel = hit(reg_addr, `PCG_GATE_FOUR_OFS);
  assign stat_sel = hit(reg_addr, `PCG_GATE_STAT_OFS);

  // ****************************************************************
  // Gate register
  // ****************************************************************
  pcg_pkg::pcg_gate_vec_t gate_ff;   // Software-requested enables
  pcg_pkg::pcg_gate_vec_t nxt_gate;  // Value after a write
  pcg_pkg::pcg_gate_vec_t live_vec;  // Enables actually at the outputs

  // Only the writable positions are kept; reserved write data is dropped
  assign nxt_gate = word_to_vec(reg_wdata & `PCG_WR_MASK);

  // Stored request bits, all gates off out of reset
  always_ff @(posedge clk) begin
    if (!rstn)                    gate_ff <= word_to_vec(`PCG_GATE_RST);
    else if (reg_wr && gate_sel)  gate_ff <= nxt_gate;
  end

  // ****************************************************************
  // Per-peripheral enable sequencers
  // ****************************************************************
  // One sequencer per gate; outputs come straight from the cell flops
  for (genvar g = 0; g < `PCG_NUM_GATES; g++) begin : g_cell
    pcg_gate_cell u_cell (
      .clk   (clk),
      .rstn  (rstn),
      .req   (gate_ff[g]),
      .en_ff (live_vec[g])
    );
  end

  assign two_wire_a_gate      = live_vec[0];
  assign two_wire_b_gate      = live_vec[1];
  assign async_serial_a_gate  = live_vec[2];
  assign async_serial_b_gate  = live_vec[3];
  assign async_serial_c_gate  = live_vec[4];
  assign usb_unit_gate        = live_vec[5];
  assign comparator_gate      = live_vec[6];
  assign serial_periph_a_gate = live_vec[7];
  assign serial_periph_b_gate = live_vec[8];

  // ****************************************************************
  // Read path
  // ****************************************************************
  pcg_pkg::pcg_word_t rd_word;  // Word selected by the read address

  // Gate register reads back the request; the status word shows what the
  // peripherals see, which lags a write by one cycle, two when the write lands in a dwell cycle
  always_comb begin
    if (gate_sel)      rd_word = vec_to_word(gate_ff);
    else if (stat_sel) rd_word = vec_to_word(live_vec);
    else               rd_word = 32'h0000_0000;
  end

  pcg_rd_port u_rd (
    .clk      (clk),
    .rstn     (rstn),
    .rd       (reg_rd),
    .rd_word  (rd_word),
    .rdata_ff (reg_rdata)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_rsv_read_ones: assert property (
    reg_rd && gate_sel |=> reg_rdata[31:28] == 4'hF && reg_rdata[5:4] == 2'b11)
    else $error("reserved one bits did not read one");

  a_rsv_read_zero: assert property (
    reg_rd && gate_sel |=> (reg_rdata & ~(`PCG_RSV_ONES | `PCG_WR_MASK)) == 32'h0000_0000)
    else $error("reserved zero bits did not read zero");

  a_serial_b_gate: assert property (
    reg_wr && gate_sel && reg_wdata[`PCG_POS_SERIAL_B] ##1 gate_ff[8] [*3] |-> serial_periph_b_gate)
    else $error("second serial gate not enabled after write of one");

  a_serial_a_gate: assert property (
    reg_wr && gate_sel && !reg_wdata[`PCG_POS_SERIAL_A] ##1 !gate_ff[7] [*3] |-> !serial_periph_a_gate)
    else $error("first serial gate not stopped after write of zero");

  a_comparator_gate: assert property (
    $rose(comparator_gate) |-> $past(gate_ff[6]))
    else $error("comparator gate rose without request");

  a_usb_gate: assert property (
    reg_wr && gate_sel |=> gate_ff[5] == $past(reg_wdata[`PCG_POS_USB]))
    else $error("usb gate bit not stored");

  a_async_c_gate: assert property (
    gate_ff[4] [*3] |-> async_serial_c_gate)
    else $error("third async serial gate not following request");

  a_async_b_gate: assert property (
    !gate_ff[3] [*3] |-> !async_serial_b_gate)
    else $error("second async serial gate not stopped");

  a_async_a_gate: assert property (
    reg_rd && gate_sel |=> reg_rdata[`PCG_POS_ASYNC_A] == $past(gate_ff[2]))
    else $error("first async serial gate readback wrong");

  a_two_wire_b: assert property (
    $fell(two_wire_b_gate) |-> !$past(gate_ff[1]))
    else $error("second two-wire gate fell while requested");

  a_two_wire_a: assert property (
    reg_wr && gate_sel && reg_wdata[`PCG_POS_TWO_WIRE_A] ##1 gate_ff[0] [*3] |-> two_wire_a_gate)
    else $error("first two-wire gate not enabled after write");

  a_reset_gates_off: assert property (
    @(posedge clk) disable iff (1'b0) !rstn |=> live_vec == 9'h000 && gate_ff == 9'h000)
    else $error("gates not off after reset");

  // ****************************************************************
  // Per-gate follow checks
  // ****************************************************************
  // Three steady cycles of a request cover a dwell cycle and the flop
  // stage, so by then every enable must agree with its request
  a_serial_b_on: assert property (
    gate_ff[8] [*3] |-> serial_periph_b_gate)
    else $error("second serial gate off while requested");

  a_serial_b_off: assert property (
    !gate_ff[8] [*3] |-> !serial_periph_b_gate)
    else $error("second serial gate on while released");

  a_serial_a_on: assert property (
    gate_ff[7] [*3] |-> serial_periph_a_gate)
    else $error("first serial gate off while requested");

  a_serial_a_off: assert property (
    !gate_ff[7] [*3] |-> !serial_periph_a_gate)
    else $error("first serial gate on while released");

  a_comparator_on: assert property (
    gate_ff[6] [*3] |-> comparator_gate)
    else $error("comparator gate off while requested");

  a_comparator_off: assert property (
    !gate_ff[6] [*3] |-> !comparator_gate)
    else $error("comparator gate on while released");

  a_usb_on: assert property (
    gate_ff[5] [*3] |-> usb_unit_gate)
    else $error("usb gate off while requested");

  a_usb_off: assert property (
    !gate_ff[5] [*3] |-> !usb_unit_gate)
    else $error("usb gate on while released");

  a_async_c_off: assert property (
    !gate_ff[4] [*3] |-> !async_serial_c_gate)
    else $error("third async serial gate on while released");

  a_async_b_on: assert property (
    gate_ff[3] [*3] |-> async_serial_b_gate)
    else $error("second async serial gate off while requested");

  a_async_a_on: assert property (
    gate_ff[2] [*3] |-> async_serial_a_gate)
    else $error("first async serial gate off while requested");

  a_async_a_off: assert property (
    !gate_ff[2] [*3] |-> !async_serial_a_gate)
    else $error("first async serial gate on while released");

  a_wire_b_on: assert property (
    gate_ff[1] [*3] |-> two_wire_b_gate)
    else $error("second two-wire gate off while requested");

  a_wire_b_off: assert property (
    !gate_ff[1] [*3] |-> !two_wire_b_gate)
    else $error("second two-wire gate on while released");

  a_wire_a_on: assert property (
    gate_ff[0] [*3] |-> two_wire_a_gate)
    else $error("first two-wire gate off while requested");

  a_wire_a_off: assert property (
    !gate_ff[0] [*3] |-> !two_wire_a_gate)
    else $error("first two-wire gate on while released");

  // ****************************************************************
  // Enable edge checks
  // ****************************************************************
  // An enable may rise only one cycle after its request was seen
  a_serial_b_rise: assert property (
    $rose(serial_periph_b_gate) |-> $past(gate_ff[8]))
    else $error("second serial gate rose without request");

  a_serial_a_rise: assert property (
    $rose(serial_periph_a_gate) |-> $past(gate_ff[7]))
    else $error("first serial gate rose without request");

  a_usb_rise: assert property (
    $rose(usb_unit_gate) |-> $past(gate_ff[5]))
    else $error("usb gate rose without request");

  a_async_c_rise: assert property (
    $rose(async_serial_c_gate) |-> $past(gate_ff[4]))
    else $error("third async serial gate rose without request");

  a_async_b_rise: assert property (
    $rose(async_serial_b_gate) |-> $past(gate_ff[3]))
    else $error("second async serial gate rose without request");

  a_async_a_rise: assert property (
    $rose(async_serial_a_gate) |-> $past(gate_ff[2]))
    else $error("first async serial gate rose without request");

  a_wire_b_rise: assert property (
    $rose(two_wire_b_gate) |-> $past(gate_ff[1]))
    else $error("second two-wire gate rose without request");

  a_wire_a_rise: assert property (
    $rose(two_wire_a_gate) |-> $past(gate_ff[0]))
    else $error("first two-wire gate rose without request");

  // ****************************************************************
  // Register port checks
  // ****************************************************************
  // Gate positions of the port words, gathered here apart from the helper
  // functions so the checks below do not lean on the logic they guard
  pcg_pkg::pcg_gate_vec_t chk_wr_bits;  // Gate positions of the write data
  pcg_pkg::pcg_gate_vec_t chk_rd_bits;  // Gate positions of the read data

  assign chk_wr_bits = {reg_wdata[`PCG_POS_SERIAL_B], reg_wdata[`PCG_POS_SERIAL_A],
                        reg_wdata[`PCG_POS_COMPARATOR], reg_wdata[`PCG_POS_USB],
                        reg_wdata[`PCG_POS_ASYNC_C], reg_wdata[`PCG_POS_ASYNC_B], reg_wdata[`PCG_POS_ASYNC_A],
                        reg_wdata[`PCG_POS_TWO_WIRE_B], reg_wdata[`PCG_POS_TWO_WIRE_A]};
  assign chk_rd_bits = {reg_rdata[`PCG_POS_SERIAL_B], reg_rdata[`PCG_POS_SERIAL_A],
                        reg_rdata[`PCG_POS_COMPARATOR], reg_rdata[`PCG_POS_USB],
                        reg_rdata[`PCG_POS_ASYNC_C], reg_rdata[`PCG_POS_ASYNC_B], reg_rdata[`PCG_POS_ASYNC_A],
                        reg_rdata[`PCG_POS_TWO_WIRE_B], reg_rdata[`PCG_POS_TWO_WIRE_A]};

  a_gate_write: assert property (
    reg_wr && gate_sel |=> gate_ff == $past(chk_wr_bits))
    else $error("gate register did not take the write");

  a_gate_hold: assert property (
    !(reg_wr && gate_sel) |=> $stable(gate_ff))
    else $error("gate register changed without a write");

  a_gate_readback: assert property (
    reg_rd && gate_sel |=> chk_rd_bits == $past(gate_ff))
    else $error("gate register readback wrong");

  a_stat_readback: assert property (
    reg_rd && stat_sel |=> chk_rd_bits == $past(live_vec))
    else $error("status readback wrong");

  a_stat_rsv_ones: assert property (
    reg_rd && stat_sel |=> reg_rdata[31:28] == 4'hF && reg_rdata[5:4] == 2'b11)
    else $error("status reserved one bits did not read one");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside its cycle");

  a_unmapped_read: assert property (
    reg_rd && !gate_sel && !stat_sel |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read did not return zero");

  c_write_gate: cover property (reg_wr && gate_sel && (reg_wdata & `PCG_WR_MASK) == `PCG_WR_MASK);
  c_read_stat:  cover property (reg_rd && stat_sel);
  c_all_on:     cover property (live_vec == 9'h1FF);
  c_toggle:     cover property ($rose(usb_unit_gate) ##[2:10] $fell(usb_unit_gate));

endmodule

// File: tb/tb_pcg_gate_bank.sv
// Self-checking testbench of the peripheral clock gate bank
`include "pcg_map.svh"

module tb_pcg_gate_bank;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic        clk       = 1'b0;    // 10 MHz system clock
  logic        rstn      = 1'b0;    // Synchronous reset, active low
  logic [15:0] reg_addr  = 16'h0000; // Register port address
  logic [31:0] reg_wdata = 32'h0000_0000; // Register port write data
  logic        reg_wr    = 1'b0;    // Write strobe
  logic        reg_rd    = 1'b0;    // Read strobe
  logic [31:0] reg_rdata;           // Registered read data
  wire  [31:0] gate_word;           // Enables gathered at their bit positions
  logic [31:0] rd_val;              // Last value read back
  int          errors    = 0;       // Mismatches seen
  int          cmp_count = 0;       // Comparisons made
  int          gate_pos [9] = '{6, 7, 10, 11, 12, 18, 19, 22, 23}; // Gate bit positions

  // ****************************************************************
  // Device under test
  // ****************************************************************
  pcg_gate_bank u_dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .two_wire_a_gate      (gate_word[6]),
    .two_wire_b_gate      (gate_word[7]),
    .async_serial_a_gate  (gate_word[10]),
    .async_serial_b_gate  (gate_word[11]),
    .async_serial_c_gate  (gate_word[12]),
    .usb_unit_gate        (gate_word[18]),
    .comparator_gate      (gate_word[19]),
    .serial_periph_a_gate (gate_word[22]),
    .serial_periph_b_gate (gate_word[23])
  );
  // Positions without a gate read as zero, so one compare covers all nine enables
  assign gate_word[31:24] = 8'h00;
  assign gate_word[21:20] = 2'b00;
  assign gate_word[17:13] = 5'b0_0000;
  assign gate_word[9:8]   = 2'b00;
  assign gate_word[5:0]   = 6'b00_0000;

  // Clock, toggled every half period
  always #50 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe, taken at the next edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // One-cycle read strobe; data is sampled once the answering edge has landed
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Enough cycles for any sequencer dwell to finish
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Out of reset every gate is off and only the fixed ones read back
  task automatic t_reset_state();
    chk("gates after reset", gate_word, 32'h0000_0000);
    rd(`PCG_GATE_FOUR_OFS, rd_val);
    chk("gate reg after reset", rd_val, 32'hF000_0030);
  endtask

  // Each gate alone: only its own enable rises, readback shows only its bit
  task automatic t_each_gate();
    for (int i = 0; i < 9; i++) begin
      wr(`PCG_GATE_FOUR_OFS, 32'h0000_0001 << gate_pos[i]);
      settle();
      chk("single gate", gate_word, 32'h0000_0001 << gate_pos[i]);
      rd(`PCG_GATE_FOUR_OFS, rd_val);
      chk("single readback", rd_val, 32'hF000_0030 | (32'h0000_0001 << gate_pos[i]));
    end
    wr(`PCG_GATE_FOUR_OFS, 32'h0000_0000);
    settle();
    chk("gates cleared", gate_word, 32'h0000_0000);
  endtask

  // Reserved bits ignore writes of ones and of zeros; bad places are harmless
  task automatic t_reserved_and_port();
    wr(`PCG_GATE_FOUR_OFS, 32'hFFFF_FFFF);
    settle();
    chk("all gates on", gate_word, 32'h00CC_1CC0);
    rd(`PCG_GATE_FOUR_OFS, rd_val);
    chk("all ones readback", rd_val, 32'hF0CC_1CF0);
    @(posedge clk);
    #1 chk("rdata after its cycle", reg_rdata, 32'h0000_0000);
    wr(`PCG_GATE_STAT_OFS, 32'h0000_0000);
    wr(16'h2000, 32'h0000_0000);
    rd(16'h2000, rd_val);
    chk("unmapped read", rd_val, 32'h0000_0000);
    rd(`PCG_GATE_STAT_OFS, rd_val);
    chk("status readback", rd_val, 32'hF0CC_1CF0);
    wr(`PCG_GATE_FOUR_OFS, 32'h0000_0000);
    rd(`PCG_GATE_FOUR_OFS, rd_val);
    chk("zeros readback", rd_val, 32'hF000_0030);
    settle();
  endtask

  // A one-cycle request still gives an enable pulse of the full dwell
  task automatic t_short_pulse();
    int high_cnt;
    high_cnt = 0;
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= `PCG_GATE_FOUR_OFS;
    reg_wdata <= 32'h0004_0000;
    @(posedge clk);
    reg_wdata <= 32'h0000_0000;
    @(posedge clk);
    reg_wr    <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      #1 if (gate_word[18] === 1'b1) high_cnt++;
      @(posedge clk);
    end
    chk("short pulse length", 32'(high_cnt), 32'h0000_0002);
    #1 chk("gates after pulse", gate_word, 32'h0000_0000);
  endtask

  // Reset in mid-run turns every gate off again
  task automatic t_mid_reset();
    wr(`PCG_GATE_FOUR_OFS, 32'hFFFF_FFFF);
    settle();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("gates in reset", gate_word, 32'h0000_0000);
    rd(`PCG_GATE_FOUR_OFS, rd_val);
    chk("gate reg after reset", rd_val, 32'hF000_0030);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset_state();
    t_each_gate();
    t_reserved_and_port();
    t_short_pulse();
    t_mid_reset();
    give_verdict();
  end

  // Cuts a hang short and counts it as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end

endmodule
